/* reset_source_controller_tb_top.sv */
`timescale 1ns/10ps
module reset_source_controller_tb_top;
  import rsc_pkg::*;
  localparam int          POR    = 20;                           // shortened power-on delay
  localparam int          EXI    = 8;                            // shortened exit limit
  localparam int          CLOCK_LOSS_DETECTOR    = 16;                           // shortened clock-loss timeout
  localparam logic [31:0] A_CAU  = {20'h0, CAUSE_IDX, 2'h0};     // cause register
  localparam logic [31:0] A_VIEW = {20'h0, ENVIEW_IDX, 2'h0};    // stored enable view
  // bus signals
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  // sources and device outputs
  logic        watchdog_expire, code_access, rst_pin_i, rst_pin_o, rst_pin_oe_n, core_reset, sp_reload;
  logic        supply_low, comparator_below, sys_clk_mon, osc_stable, port_open_drain, weak_pullup_en, restart;
  logic        supply_monitor_en, clock_loss_detector_en;
  logic [12:0] code_addr;
  logic [7:0]  port_latch_val, m_flags;
  logic [15:0] restart_pc;
  logic [3:0]  wdt_clk_div;
  // partner controls and model enables
  logic        ext_pull_low, supply_dip, cmp_dip, clk_halt, osc_slow, m_mon, m_cl, m_cmp;
  int          num_errors, n_compared;

  rsc_top #(.MEM_SEL(MEM_8K), .MCD_CYC(CLOCK_LOSS_DETECTOR), .POR_CYC(POR), .EXIT_CYC(EXI)) rsc_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .supply_low(supply_low), .comparator_below(comparator_below),
    .sys_clk_mon(sys_clk_mon), .osc_stable(osc_stable), .watchdog_expire(watchdog_expire),
    .code_access(code_access), .code_addr(code_addr), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe_n(rst_pin_oe_n), .core_reset(core_reset), .sp_reload(sp_reload),
    .port_latch_val(port_latch_val), .port_open_drain(port_open_drain), .weak_pullup_en(weak_pullup_en),
    .restart(restart), .restart_pc(restart_pc), .wdt_clk_div(wdt_clk_div),
    .supply_monitor_en(supply_monitor_en), .clock_loss_detector_en(clock_loss_detector_en));
  rsc_partner_model rsc_partner_model_i (
    .hclk(hclk), .rst_pin_o(rst_pin_o), .rst_pin_oe_n(rst_pin_oe_n), .ext_pull_low(ext_pull_low),
    .supply_dip(supply_dip), .cmp_dip(cmp_dip), .clk_halt(clk_halt), .osc_slow(osc_slow),
    .rst_pin_i(rst_pin_i), .supply_low(supply_low), .comparator_below(comparator_below),
    .sys_clk_mon(sys_clk_mon), .osc_stable(osc_stable));

  // 100 ns clock
  always #50 hclk = ~hclk;

  // xorshift source of stimulus values
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // counts and reports one comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // single ahb-lite transfer, read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= wr; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask : ahb

  // register write, model keeps the stored enables
  task automatic reg_wr(input logic [31:0] v);
    ahb(1'b1, A_CAU, v);
    m_mon = v[1]; m_cl = v[2]; m_cmp = v[5];
  endtask : reg_wr

  // flags, enable view and enable outputs against the model
  task automatic check_regs();
    ahb(1'b0, A_CAU, xs());
    check(rd, {24'h0, m_flags});
    ahb(1'b0, A_VIEW, xs());
    check(rd, {26'h0, m_cmp, 2'h0, m_cl, m_mon, 1'b0});
    check({30'h0, supply_monitor_en, clock_loss_detector_en}, {30'h0, m_mon, m_cl});
  endtask : check_regs

  // core_reset must stay low for n cycles
  task automatic no_reset(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge hclk);
      if (core_reset !== 1'b0) bad = 1'b1;
    end
    check({31'h0, bad}, 32'h0);
  endtask : no_reset

  // waits for a reset, checks its length, pin drive and restart, then the registers
  task automatic expect_reset(input logic [7:0] cause, input logic drv, input logic por, input int lo, input int hi);
    int   n;
    logic dr, sp;
    n = 0; dr = 1'b0; sp = 1'b0;
    while (core_reset !== 1'b1 && n < 64) begin
      @(negedge hclk);
      n++;
    end
    check({31'h0, core_reset}, 32'h1);
    check({16'h0, port_latch_val, 7'h0, port_open_drain}, {16'h0, PORT_RESET, 8'h01});
    n = 0;
    while (core_reset === 1'b1 && n < 4000) begin
      if (rst_pin_oe_n === 1'b0) dr = 1'b1;
      if (sp_reload === 1'b1) sp = 1'b1;
      @(negedge hclk);
      n++;
    end
    check({31'h0, (n >= lo && n <= hi)}, 32'h1);
    check({31'h0, dr}, {31'h0, drv});
    if (!por) check({31'h0, sp}, 32'h1);
    check({10'h0, restart, restart_pc, wdt_clk_div, weak_pullup_en}, {10'h0, 1'b1, PC_RESET, WDT_DIV, 1'b1});
    m_flags = cause; m_cl = 1'b0; m_cmp = 1'b0;
    if (por) m_mon = 1'b0;
    check_regs();
  endtask : expect_reset

  // one-cycle watchdog or code-access event
  task automatic pulse(input logic wd, input logic [12:0] a);
    @(posedge hclk);
    watchdog_expire <= wd; code_access <= !wd; code_addr <= a;
    @(posedge hclk);
    watchdog_expire <= 1'b0; code_access <= 1'b0;
  endtask : pulse

  // holds one partner control high for n cycles
  task automatic dip(input int k, input int n);
    @(posedge hclk);
    case (k)
      0: ext_pull_low <= 1'b1;
      1: supply_dip <= 1'b1;
      2: cmp_dip <= 1'b1;
      default: clk_halt <= 1'b1;
    endcase
    fork
      begin
        repeat (n) @(posedge hclk);
        {ext_pull_low, supply_dip, cmp_dip, clk_halt} <= 4'h0;
      end
    join_none
  endtask : dip

  // prints counts and the verdict, then stops
  task results();
    $display("counts: %0d compared, %0d mismatched", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // hang guard well beyond the expected run
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results();
  end

  // main sequence
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    watchdog_expire = 0; code_access = 0; code_addr = 0; ext_pull_low = 0; supply_dip = 0;
    cmp_dip = 0; clk_halt = 0; osc_slow = 0; seed = 32'd64721; num_errors = 0; n_compared = 0;
    m_flags = 0; m_mon = 0; m_cl = 0; m_cmp = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    expect_reset(8'h02, 1'b1, 1'b1, POR, POR + EXI + 6);
    $display("test power_on done");
    reg_wr(32'h2);
    expect_reset(8'h02, 1'b1, 1'b0, 1, 40);
    reg_wr(32'h2);
    no_reset(10);
    $display("test monitor_enable done");
    @(posedge hclk);
    osc_slow <= 1'b1;
    reg_wr(32'h12);
    expect_reset(8'h10, 1'b0, 1'b0, EXI, 40);
    osc_slow <= 1'b0;
    reg_wr(32'h82);
    no_reset(6);
    check_regs();
    ahb(1'b1, 32'h800, 32'hff);
    ahb(1'b0, 32'h800, xs());
    check(rd, 32'h0);
    no_reset(6);
    $display("test software_and_bit7 done");
    dip(0, 10);
    expect_reset(8'h01, 1'b0, 1'b0, 10, 40);
    pulse(1'b1, 13'h0);
    expect_reset(8'h08, 1'b0, 1'b0, 1, 40);
    for (int i = 0; i < 8; i++) pulse(1'b0, 13'(xs() % (LIMIT_8K + 13'h1)));
    pulse(1'b0, LIMIT_8K);
    no_reset(6);
    pulse(1'b0, LIMIT_8K + 13'h1);
    expect_reset(8'h40, 1'b0, 1'b0, 1, 40);
    $display("test pin_watchdog_code done");
    reg_wr(32'h6);
    check_regs();
    dip(3, CLOCK_LOSS_DETECTOR + 8);
    no_reset(CLOCK_LOSS_DETECTOR - 2);
    expect_reset(8'h04, 1'b0, 1'b0, 1, 40);
    dip(2, 10);
    no_reset(12);
    reg_wr(32'h22);
    dip(2, 6);
    expect_reset(8'h20, 1'b0, 1'b0, 6, 40);
    dip(1, 4);
    expect_reset(8'h02, 1'b1, 1'b0, 4, POR - 1);
    reg_wr(32'h0);
    dip(1, 4);
    no_reset(12);
    check_regs();
    $display("test clock_comparator_supply done");
    results();
  end
endmodule : reset_source_controller_tb_top

/* rsc_partner_model.sv */
`timescale 1ns/10ps
// far side of the reset block: external reset line, supply and clock sources
module rsc_partner_model (
  // clock
  input  wire logic hclk,
  // device side of the open-drain reset pin
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe_n,
  // scenario controls from the bench
  input  wire logic ext_pull_low,
  input  wire logic supply_dip,
  input  wire logic cmp_dip,
  input  wire logic clk_halt,
  input  wire logic osc_slow,
  // levels seen by the device
  output logic      rst_pin_i,
  output logic      supply_low,
  output logic      comparator_below,
  output logic      sys_clk_mon,
  output logic      osc_stable
);
  // wired line with a pull-up: any party pulling low wins, otherwise high
  assign rst_pin_i = ((!rst_pin_oe_n && !rst_pin_o) || ext_pull_low) ? 1'b0 : 1'b1;
  // analog levels follow the bench controls
  assign supply_low       = supply_dip;
  assign comparator_below = cmp_dip;
  // a slow oscillator never reports stable, so exit runs to its limit
  assign osc_stable = !osc_slow;
  // monitored clock toggles every cycle unless halted
  initial sys_clk_mon = 1'b0;
  always @(posedge hclk) begin
    if (!clk_halt) sys_clk_mon <= ~sys_clk_mon;
  end
endmodule : rsc_partner_model

/* rsc_pkg.sv */
// shared constants for the reset source controller
package rsc_pkg;

  // clock and timing figures
  localparam int  CLK_PERIOD_NS   = 100;                            // hclk period
  localparam int  MCD_TIMEOUT_US  = 100;                            // missing clock timeout
  localparam int  MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam real POR_DELAY_MS    = 0.3;                            // power-on release delay
  localparam int  POR_DELAY_CYC   = int'($ceil(POR_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int  EXIT_MAX_US     = 60;                             // release to execution, max
  localparam int  EXIT_MAX_CYC    = EXIT_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int  EXIT_MIN_CYC    = 3;                              // pin settle after release
  localparam int  CNT_W           = 12;                             // timer width

  // register map: printed offset is an index, byte address is four times it
  localparam logic [9:0] CAUSE_IDX = 10'h0ff;                      // cause / enable register
  localparam logic [9:0] ENVIEW_IDX = 10'h100;                     // stored enable view

  // reset cause / enable bit positions
  localparam int BIT_PIN = 0;
  localparam int BIT_POR = 1;
  localparam int BIT_MCD = 2;
  localparam int BIT_WDT = 3;
  localparam int BIT_SW  = 4;
  localparam int BIT_CMP = 5;
  localparam int BIT_OTP = 6;
  localparam int FLAG_W  = 7;                                       // bit 7 is unused
  localparam logic [FLAG_W-1:0] FLAGS_POR_ONLY = 7'h02;             // flags after power-on

  // user code space limits, by memory size selection
  localparam logic [1:0]  MEM_8K    = 2'h0;
  localparam logic [1:0]  MEM_4K    = 2'h1;
  localparam logic [1:0]  MEM_2K    = 2'h2;
  localparam logic [12:0] LIMIT_8K  = 13'h1dff;
  localparam logic [12:0] LIMIT_4K  = 13'h0fff;
  localparam logic [12:0] LIMIT_2K  = 13'h07ff;

  // restart values
  localparam logic [3:0]  WDT_DIV    = 4'hc;                       // watchdog clock divider
  localparam logic [15:0] PC_RESET   = 16'h0000;                   // execution start address
  localparam logic [7:0]  PORT_RESET = 8'hff;                      // port latch value in reset

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // controller states
  typedef enum logic [2:0] {
    ST_POR_DELAY,
    ST_HOLD,
    ST_EXIT,
    ST_RUN
  } rsc_state_t;

endpackage : rsc_pkg

/* rsc_top.sv */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module rsc_top #(
  parameter logic [1:0] MEM_SEL  = rsc_pkg::MEM_8K,         // code memory size selection
  parameter int         MCD_CYC  = rsc_pkg::MCD_TIMEOUT_CYC, // missing clock timeout, cycles
  parameter int         POR_CYC  = rsc_pkg::POR_DELAY_CYC,   // power-on release delay, cycles
  parameter int         EXIT_CYC = rsc_pkg::EXIT_MAX_CYC     // longest exit wait, cycles
) (
  // clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // asynchronous reset sources and oscillator status
  input  wire logic        supply_low,
  input  wire logic        comparator_below,
  input  wire logic        sys_clk_mon,
  input  wire logic        osc_stable,
  // same-clock reset sources
  input  wire logic        watchdog_expire,
  input  wire logic        code_access,
  input  wire logic [12:0] code_addr,
  // reset pin, open drain
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe_n,
  // reset state to the core
  output logic             core_reset,
  output logic             sp_reload,
  output logic [7:0]       port_latch_val,
  output logic             port_open_drain,
  output logic             weak_pullup_en,
  // restart controls
  output logic             restart,
  output logic [15:0]      restart_pc,
  output logic [3:0]       wdt_clk_div,
  // enables seen by monitors
  output logic             supply_monitor_en,
  output logic             clock_loss_detector_en
);
  import rsc_pkg::*;

  // timer limits sized to the counters
  localparam logic [CNT_W-1:0] MCD_LIM  = CNT_W'(MCD_CYC);
  localparam logic [CNT_W-1:0] POR_LIM  = CNT_W'(POR_CYC - 1);
  localparam logic [CNT_W-1:0] EXIT_LIM = CNT_W'(EXIT_CYC - 1);
  localparam logic [CNT_W-1:0] EXIT_MIN = CNT_W'(EXIT_MIN_CYC);
  localparam int               EXIT_WIN = EXIT_MAX_CYC;       // exit bound for checks

  // whole state of the controller
  typedef struct packed {
    rsc_state_t        st;          // controller state
    logic [CNT_W-1:0]  cnt;         // delay counter
    logic [CNT_W-1:0]  mcd_cnt;     // cycles since last monitored clock edge
    logic              pin_s1;      // pin synchroniser
    logic              pin_s2;
    logic              sup_s1;      // supply low synchroniser
    logic              sup_s2;
    logic              cmp_s1;      // comparator synchroniser
    logic              cmp_s2;
    logic              mon_s1;      // monitored clock synchroniser
    logic              mon_s2;
    logic              mon_s3;      // previous monitored level
    logic              osc_s1;      // oscillator stable synchroniser
    logic              osc_s2;
    logic [FLAG_W-1:0] flags;       // last reset cause
    logic              en_mon;      // supply monitor enable
    logic              en_mcd;      // clock-loss detector enable
    logic              en_cmp;      // comparator reset enable
    logic              sp_pls;      // stack pointer reload pulse
    logic              exit_pls;    // restart pulse
    logic              wr_hit;      // write data phase pending
    logic [31:0]       rdata;       // read data
  } rsc_regs_t;

  localparam rsc_regs_t REGS_RST = '{st: ST_POR_DELAY, pin_s1: 1'h1, pin_s2: 1'h1,
                                     flags: FLAGS_POR_ONLY, default: '0};

  rsc_regs_t s_reg;   // registered state
  rsc_regs_t s_next;  // next state

  // user code limit for the selected memory size
  function automatic logic [12:0] code_limit(input logic [1:0] sel);
    case (sel)
      MEM_4K:  code_limit = LIMIT_4K;
      MEM_2K:  code_limit = LIMIT_2K;
      default: code_limit = LIMIT_8K;
    endcase
  endfunction : code_limit

  // source decode
  logic              pin_low;     // synchronised pin low, including our own drive
  logic              drive;       // pulling the reset pin low
  logic              src_pin;
  logic              src_sup;
  logic              src_cmp;
  logic              src_mcd;
  logic              src_otp;
  logic              src_sw;
  logic              src_monwr;
  logic              armed;       // new sources are being accepted
  logic              src_any;
  logic              acc;         // bus address phase accepted
  logic              hit_cause;
  logic              hit_view;
  logic [FLAG_W-1:0] cause;

  // level and event sources
  always_comb begin
    drive     = (s_reg.st != ST_RUN) && (s_reg.st != ST_EXIT) && s_reg.flags[BIT_POR];
    pin_low   = !s_reg.pin_s2;
    src_pin   = pin_low;
    src_sup   = s_reg.en_mon && s_reg.sup_s2;
    src_cmp   = s_reg.en_cmp && s_reg.cmp_s2;
    src_mcd   = s_reg.en_mcd && (s_reg.mcd_cnt == MCD_LIM);
    src_otp   = code_access && (code_addr > code_limit(MEM_SEL));
    src_sw    = s_reg.wr_hit && hwdata[BIT_SW];
    src_monwr = s_reg.wr_hit && hwdata[BIT_POR] && !s_reg.en_mon;
    armed     = (s_reg.st == ST_RUN) || ((s_reg.st == ST_EXIT) && (s_reg.cnt >= EXIT_MIN));
    src_any   = src_pin || src_sup || src_cmp || src_mcd || src_otp || watchdog_expire
                || (s_reg.st == ST_RUN && (src_sw || src_monwr));
  end

  // cause vector captured at reset entry
  always_comb begin
    cause = '0;
    if (src_sup || (s_reg.st == ST_RUN && src_monwr)) begin
      cause[BIT_POR] = 1'h1;
    end else begin
      cause[BIT_PIN] = src_pin;
      cause[BIT_MCD] = src_mcd;
      cause[BIT_WDT] = watchdog_expire;
      cause[BIT_SW]  = s_reg.st == ST_RUN && src_sw;
      cause[BIT_CMP] = src_cmp;
      cause[BIT_OTP] = src_otp;
    end
  end

  // bus address decode
  always_comb begin
    acc       = hsel && hready && (htrans == HTRANS_NONSEQ);
    hit_cause = haddr[11:2] == CAUSE_IDX;
    hit_view  = haddr[11:2] == ENVIEW_IDX;
  end

  // next state
  always_comb begin
    s_next          = s_reg;
    s_next.sp_pls   = 1'h0;
    s_next.exit_pls = 1'h0;
    // synchronisers
    s_next.pin_s1 = rst_pin_i;
    s_next.pin_s2 = s_reg.pin_s1;
    s_next.sup_s1 = supply_low;
    s_next.sup_s2 = s_reg.sup_s1;
    s_next.cmp_s1 = comparator_below;
    s_next.cmp_s2 = s_reg.cmp_s1;
    s_next.mon_s1 = sys_clk_mon;
    s_next.mon_s2 = s_reg.mon_s1;
    s_next.mon_s3 = s_reg.mon_s2;
    s_next.osc_s1 = osc_stable;
    s_next.osc_s2 = s_reg.osc_s1;
    // missing clock one-shot: any edge restarts it
    if (!s_reg.en_mcd || (s_reg.mon_s2 != s_reg.mon_s3)) begin
      s_next.mcd_cnt = '0;
    end else if (s_reg.mcd_cnt != MCD_LIM) begin
      s_next.mcd_cnt = s_reg.mcd_cnt + 1'h1;
    end
    // bus: reads registered at the address phase
    s_next.wr_hit = acc && hwrite && (hit_cause || hit_view);
    s_next.rdata  = '0;
    if (acc && !hwrite && hit_cause) begin
      s_next.rdata[FLAG_W-1:0] = s_reg.flags;
    end else if (acc && !hwrite && hit_view) begin
      s_next.rdata[BIT_POR] = s_reg.en_mon;
      s_next.rdata[BIT_MCD] = s_reg.en_mcd;
      s_next.rdata[BIT_CMP] = s_reg.en_cmp;
    end
    // write data phase, only while the core runs; bit 7 is dropped
    if (s_reg.wr_hit && s_reg.st == ST_RUN) begin
      s_next.en_mon = hwdata[BIT_POR];
      s_next.en_mcd = hwdata[BIT_MCD];
      s_next.en_cmp = hwdata[BIT_CMP];
    end
    // sequencer
    case (s_reg.st)
      // power-up release delay
      ST_POR_DELAY: begin
        s_next.cnt = s_reg.cnt + 1'h1;
        if (s_reg.cnt == POR_LIM) begin
          s_next.st  = ST_EXIT;
          s_next.cnt = '0;
        end
      end
      // held by a level source; pin ignored while we drive it
      ST_HOLD: begin
        if (!(src_sup || src_cmp || (src_pin && !drive))) begin
          s_next.st     = ST_EXIT;
          s_next.cnt    = '0;
          // comparator enable returns to its reset value once the hold ends
          s_next.en_cmp = 1'h0;
        end
      end
      // wait for a stable clock, bounded
      ST_EXIT: begin
        s_next.cnt = s_reg.cnt + 1'h1;
        if (s_reg.cnt >= EXIT_MIN && (s_reg.osc_s2 || s_reg.cnt >= EXIT_LIM)) begin
          s_next.st       = ST_RUN;
          s_next.exit_pls = 1'h1;
        end
      end
      ST_RUN: begin
        s_next.cnt = '0;
      end
      default: begin
        s_next.st = ST_HOLD;
      end
    endcase
    // reset entry: latch cause, clear clock-loss enable, keep monitor
    if (armed && src_any) begin
      s_next.st     = ST_HOLD;
      s_next.cnt    = '0;
      s_next.flags  = cause;
      s_next.sp_pls = 1'h1;
      s_next.en_mcd = 1'h0;
      // a comparator reset keeps its enable so the hold lasts while the input
      // stays below; any other cause drops it at once
      s_next.en_cmp = src_cmp;
      s_next.en_mon = s_reg.en_mon || (s_reg.st == ST_RUN && src_monwr);
    end
  end

  // state register; power-on clears the monitor enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= REGS_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs
  always_comb begin
    hreadyout              = 1'h1;
    hresp                  = HRESP_OKAY;
    hrdata                 = s_reg.rdata;
    rst_pin_o              = 1'h0;
    rst_pin_oe_n           = !drive;
    core_reset             = s_reg.st != ST_RUN;
    sp_reload              = s_reg.sp_pls;
    port_latch_val         = PORT_RESET;
    port_open_drain        = core_reset;
    weak_pullup_en         = 1'h1;
    restart                = s_reg.exit_pls;
    restart_pc             = PC_RESET;
    wdt_clk_div            = WDT_DIV;
    supply_monitor_en      = s_reg.en_mon;
    clock_loss_detector_en = s_reg.en_mcd;
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // a supply or monitor-enable reset in the same cycle reports as power-on,
  // so the single-cause checks below leave those cycles out
  chk_pin_drive: assert property (!rst_pin_oe_n |-> core_reset && s_reg.flags[BIT_POR])
    else $error("reset pin driven outside a power reset");
  chk_sw_force: assert property (s_reg.st == ST_RUN && src_sw && !src_sup && !src_monwr
    |=> core_reset && s_reg.flags[BIT_SW] && !s_reg.flags[BIT_POR])
    else $error("software reset not taken");
  chk_otp_limit: assert property (s_reg.st == ST_RUN && code_access && !src_sup && !src_monwr
    && code_addr > code_limit(MEM_SEL) |=> core_reset && s_reg.flags[BIT_OTP])
    else $error("code limit access did not reset");
  chk_mcd_timeout: assert property (s_reg.st == ST_RUN && src_mcd && !src_sup && !src_monwr
    |=> core_reset && s_reg.flags[BIT_MCD] && !clock_loss_detector_en)
    else $error("clock loss did not reset");
  chk_mon_keep: assert property ($rose(core_reset) |-> supply_monitor_en || !$past(supply_monitor_en))
    else $error("monitor enable lost on reset");
  chk_mon_write: assert property (s_reg.st == ST_RUN && src_monwr
    |=> core_reset && supply_monitor_en && s_reg.flags[BIT_POR])
    else $error("monitor enable did not reset");
  chk_exit_bound: assert property ($rose(s_reg.st == ST_EXIT) |-> ##[1:EXIT_WIN] restart)
    else $error("exit took too long");
  chk_restart_pulse: assert property (restart |-> $past(core_reset) && !core_reset ##1 !restart)
    else $error("restart pulse malformed");
  // every reset entered from run reloads the stack pointer in its first cycle
  chk_sp_reload: assert property ($rose(core_reset) |-> sp_reload)
    else $error("stack pointer not reloaded on reset");
  chk_pin_flag: assert property (s_reg.st == ST_RUN && src_pin && !src_sup && !src_monwr
    |=> core_reset && s_reg.flags[BIT_PIN])
    else $error("pin reset not taken");
  chk_wdt_flag: assert property (s_reg.st == ST_RUN && watchdog_expire && !src_sup && !src_monwr
    |=> core_reset && s_reg.flags[BIT_WDT] && !s_reg.flags[BIT_POR])
    else $error("watchdog reset not taken");
  // level sources keep the controller in hold
  chk_sup_hold: assert property (s_reg.st == ST_HOLD && src_sup |=> core_reset)
    else $error("supply hold released");
  // the pin is pulled only after a power-type cause
  chk_pin_quiet: assert property (core_reset && !s_reg.flags[BIT_POR] |-> rst_pin_oe_n)
    else $error("reset pin driven by a non-power reset");
  chk_top_bit: assert property ($past(acc && !hwrite) |-> hrdata[7] == 1'h0)
    else $error("unused bit read as one");
  chk_port_state: assert property (core_reset |-> port_open_drain && port_latch_val == PORT_RESET)
    else $error("ports not quiet in reset");
  chk_cmp_hold: assert property (s_reg.st == ST_HOLD && src_cmp |=> core_reset)
    else $error("comparator hold released");

endmodule : rsc_top
